// *** hdl/lpg_top.sv ***
// Indicator pulse generators and PWM generator with APB registers
`timescale 1ns/1ps
`include "lpg_cfg.svh"

module lpg_top #(
  parameter int unsigned LF_DIV_CYCLES = `LPG_LF_DIV
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`LPG_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Indicator outputs
  output logic                         first_indicator_out,
  output logic                         second_indicator_out,
  // PWM and general-purpose pin
  output logic                         pwm_out,
  input  wire logic                    gpio_in,
  output logic                         gpio_out,
  output logic                         gpio_oe
);
  import lpg_pkg::*;

  // ==========================================================
  // Register storage
  logic [5:0]   period_ctrl;
  logic [5:0]   pulse_ctrl;
  logic [1:0]   pulse_rate_select;
  logic [7:0]   pulse_high_fraction;
  lpg_pin_cfg_t pin_cfg;

  // ==========================================================
  // APB decode
  wire logic access     = psel && penable;
  wire logic setup      = psel && !penable;
  wire logic wr_en      = access && pwrite;
  wire logic hit_period = (paddr == `LPG_ADDR_PERIOD);
  wire logic hit_pulse  = (paddr == `LPG_ADDR_PULSE);
  wire logic hit_freq   = (paddr == `LPG_ADDR_PULSE_RATE_SELECT);
  wire logic hit_duty   = (paddr == `LPG_ADDR_PWM_DUTY);
  wire logic hit_pin    = (paddr == `LPG_ADDR_PIN);
  wire logic hit_status = (paddr == `LPG_ADDR_STATUS);
  wire logic hit_any    = hit_period || hit_pulse || hit_freq || hit_duty
                          || hit_pin || hit_status;
  // Status is read-only, so a write to it is refused too
  wire logic bad_access = !hit_any || (pwrite && hit_status);

  // Zero wait states; error only in the access phase
  assign pready  = 1'b1;
  assign pslverr = access && bad_access;

  // ==========================================================
  // Pin input synchroniser
  logic gpio_meta;
  logic gpio_sync;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gpio_meta <= 1'b0;
      gpio_sync <= 1'b0;
    end else begin
      gpio_meta <= gpio_in;
      gpio_sync <= gpio_meta;
    end
  end

  // ==========================================================
  // Read data
  wire logic [31:0] status_word = {28'h0000000, gpio_sync, pwm_out,
                                   second_indicator_out, first_indicator_out};
  wire logic [31:0] rd_mux =
      hit_period ? {26'h0000000, period_ctrl} :
      hit_pulse  ? {26'h0000000, pulse_ctrl} :
      hit_freq   ? {30'h00000000, pulse_rate_select} :
      hit_duty   ? {24'h000000, pulse_high_fraction} :
      hit_pin    ? {29'h00000000, pin_cfg} :
      hit_status ? status_word : 32'h00000000;

  // Captured in setup so the access phase sees stable data
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ==========================================================
  // Register writes
  // General reset clears fields
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      period_ctrl         <= `LPG_RST_PERIOD;
      pulse_ctrl          <= `LPG_RST_PULSE;
      pulse_rate_select   <= `LPG_RST_PULSE_RATE_SELECT;
      pulse_high_fraction <= `LPG_RST_PWM_DUTY;
      pin_cfg             <= lpg_pin_cfg_t'(`LPG_RST_PIN);
    end else if (wr_en) begin
      if (hit_period) begin
        period_ctrl <= pwdata[5:0];
      end
      if (hit_pulse) begin
        pulse_ctrl <= pwdata[5:0];
      end
      if (hit_freq) begin
        pulse_rate_select <= pwdata[`LPG_PWM_RATE];
      end
      if (hit_duty) begin
        pulse_high_fraction <= pwdata[7:0];
      end
      if (hit_pin) begin
        pin_cfg <= lpg_pin_cfg_t'(pwdata[2:0]);
      end
    end
  end

  // ==========================================================
  // Low-frequency tick divider
  localparam int unsigned LF_CNT_W = $clog2(LF_DIV_CYCLES);
  logic [LF_CNT_W-1:0] lf_cnt;
  wire logic lf_tick = (lf_cnt == LF_CNT_W'(LF_DIV_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lf_cnt <= '0;
    end else begin
      lf_cnt <= lf_tick ? '0 : LF_CNT_W'(lf_cnt + 1'b1);
    end
  end

  // ==========================================================
  // Indicator generators
  lpg_ind_cfg_t ind_cfg     [2];
  lpg_ind_cfg_t ind_cfg_q   [2];
  logic         ind_restart [2];
  logic         ind_on      [2];

  assign ind_cfg[0] = '{dbl:    pulse_ctrl[`LPG_FIRST_DOUBLE],
                        width:  pulse_ctrl[`LPG_FIRST_WIDTH],
                        period: period_ctrl[`LPG_FIRST_PERIOD]};
  assign ind_cfg[1] = '{dbl:    pulse_ctrl[`LPG_SECOND_DOUBLE],
                        width:  pulse_ctrl[`LPG_SECOND_WIDTH],
                        period: period_ctrl[`LPG_SECOND_PERIOD]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ind
      assign ind_restart[gi] = (ind_cfg[gi] != ind_cfg_q[gi]);

      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          ind_cfg_q[gi] <= lpg_ind_cfg_t'(0);
        end else begin
          ind_cfg_q[gi] <= ind_cfg[gi];
        end
      end

      lpg_blink_gen u_blink (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .lf_tick  (lf_tick),
        .restart  (ind_restart[gi]),
        .cfg      (ind_cfg[gi]),
        .led_on   (ind_on[gi])
      );
    end
  endgenerate

  assign first_indicator_out  = ind_on[0];
  assign second_indicator_out = ind_on[1];

  // ==========================================================
  // PWM step divider
  localparam int unsigned PWM_STEP_CYCLES = `LPG_PWM_STEP_CYCLES;
  localparam int unsigned PWM_CNT_W       = $clog2(PWM_STEP_CYCLES);
  logic [PWM_CNT_W-1:0] step_cnt;
  logic [2:0]           prescale;
  logic [7:0]           pwm_phase;
  logic [1:0]           rate_q;
  logic [7:0]           duty_q;
  logic                 next_pwm_out;

  // Step length is rounded down, so 500 Hz comes out a hair fast
  wire logic step_tick   = (step_cnt == PWM_CNT_W'(PWM_STEP_CYCLES - 1));
  // Rate divides step by 1, 2, 4, 8
  wire logic [2:0] pre_max = 3'((4'h1 << pulse_rate_select) - 4'h1);
  wire logic pre_wrap    = step_tick && (prescale >= pre_max);
  wire logic pwm_restart = (rate_q != pulse_rate_select)
                           || (duty_q != pulse_high_fraction);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= (step_tick || pwm_restart) ? '0 : PWM_CNT_W'(step_cnt + 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale  <= 3'h0;
      pwm_phase <= 8'h00;
      rate_q    <= `LPG_RST_PULSE_RATE_SELECT;
      duty_q    <= `LPG_RST_PWM_DUTY;
    end else begin
      rate_q <= pulse_rate_select;
      duty_q <= pulse_high_fraction;
      if (pwm_restart) begin
        prescale  <= 3'h0;
        pwm_phase <= 8'h00;
      end else if (pre_wrap) begin
        prescale  <= 3'h0;
        pwm_phase <= 8'(pwm_phase + 8'h01);
      end else if (step_tick) begin
        prescale <= 3'(prescale + 3'h1);
      end
    end
  end

  // High for N of 256 steps
  assign next_pwm_out = (pwm_phase < pulse_high_fraction) && !pwm_restart;

  // ==========================================================
  // Pin drivers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_out  <= 1'b0;
      gpio_out <= 1'b0;
      gpio_oe  <= 1'b0;
    end else begin
      pwm_out <= next_pwm_out;
      gpio_out <= pin_cfg.pwm_sel ? next_pwm_out : pin_cfg.level;
      gpio_oe  <= pin_cfg.drive;
    end
  end

endmodule // lpg_top

// *** inc/lpg_cfg.svh ***
// Constants for the indicator pulse and PWM generator
`ifndef LPG_CFG_SVH
`define LPG_CFG_SVH

// ==========================================================
// Clocks and time bases
`define LPG_CORE_HZ           200000000
`define LPG_LF_KHZ            32
`define LPG_LF_DIV            (`LPG_CORE_HZ / (`LPG_LF_KHZ * 1000))
`define LPG_ON_BASE_US        62500
`define LPG_ON_BASE_TICKS     (`LPG_ON_BASE_US * `LPG_LF_KHZ / 1000)
`define LPG_PERIOD_BASE_MS    125
`define LPG_PERIOD_BASE_TICKS (`LPG_PERIOD_BASE_MS * `LPG_LF_KHZ)
`define LPG_PWM_BASE_HZ       500
`define LPG_PWM_STEPS         256
`define LPG_PWM_STEP_CYCLES   (`LPG_CORE_HZ / (`LPG_PWM_BASE_HZ * `LPG_PWM_STEPS))

// ==========================================================
// Register indices and byte addresses
`define LPG_ADDR_W            12
`define LPG_IDX_PERIOD        10'h06c
`define LPG_IDX_PULSE         10'h06d
`define LPG_IDX_PULSE_RATE_SELECT      10'h06e
`define LPG_IDX_PWM_DUTY      10'h06f
`define LPG_IDX_PIN           10'h071
`define LPG_IDX_STATUS        10'h072
`define LPG_ADDR_PERIOD       {`LPG_IDX_PERIOD, 2'b00}
`define LPG_ADDR_PULSE        {`LPG_IDX_PULSE, 2'b00}
`define LPG_ADDR_PULSE_RATE_SELECT     {`LPG_IDX_PULSE_RATE_SELECT, 2'b00}
`define LPG_ADDR_PWM_DUTY     {`LPG_IDX_PWM_DUTY, 2'b00}
`define LPG_ADDR_PIN          {`LPG_IDX_PIN, 2'b00}
`define LPG_ADDR_STATUS       {`LPG_IDX_STATUS, 2'b00}

// ==========================================================
// Field positions
`define LPG_FIRST_PERIOD      2:0
`define LPG_SECOND_PERIOD     5:3
`define LPG_FIRST_WIDTH       1:0
`define LPG_SECOND_WIDTH      3:2
`define LPG_FIRST_DOUBLE      4
`define LPG_SECOND_DOUBLE     5
`define LPG_PWM_RATE          1:0
`define LPG_PIN_LEVEL         0
`define LPG_PIN_DRIVE         1
`define LPG_PIN_PWM_SEL       2

// ==========================================================
// Reset values
`define LPG_RST_PERIOD        6'h00
`define LPG_RST_PULSE         6'h00
`define LPG_RST_PULSE_RATE_SELECT      2'h0
`define LPG_RST_PWM_DUTY      8'h00
`define LPG_RST_PIN           3'h0

`endif

// *** inc/lpg_pkg.sv ***
// Types and decode functions for the indicator pulse and PWM generator
`include "lpg_cfg.svh"

package lpg_pkg;

  // ==========================================================
  // Carriers
  typedef logic [17:0] lpg_tick_t;

  typedef struct packed {
    logic       dbl;
    logic [1:0] width;
    logic [2:0] period;
  } lpg_ind_cfg_t;

  typedef struct packed {
    logic pwm_sel;
    logic drive;
    logic level;
  } lpg_pin_cfg_t;

  typedef enum logic [1:0] {
    LPG_ST_OFF = 2'b01,
    LPG_ST_RUN = 2'b10
  } lpg_blink_st_t;

  // ==========================================================
  // Decoders
  function automatic lpg_tick_t lpg_period_ticks(input logic [2:0] code);
    lpg_tick_t base;
    base = lpg_tick_t'(`LPG_PERIOD_BASE_TICKS);
    return (code == 3'h0) ? lpg_tick_t'(0) : lpg_tick_t'(base << (code - 3'h1));
  endfunction

  function automatic lpg_tick_t lpg_width_ticks(input logic [1:0] code);
    lpg_tick_t base;
    base = lpg_tick_t'(`LPG_ON_BASE_TICKS);
    return lpg_tick_t'(base << code);
  endfunction

endpackage

// *** hdl/lpg_blink_gen.sv ***
// One indicator pulse generator counting low-frequency ticks
`timescale 1ns/1ps

module lpg_blink_gen (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // Timing and control
  input  wire logic                 lf_tick,
  input  wire logic                 restart,
  input  wire lpg_pkg::lpg_ind_cfg_t cfg,
  // Indicator drive
  output logic                      led_on
);
  import lpg_pkg::*;

  // ==========================================================
  // Decode
  lpg_blink_st_t state;
  lpg_blink_st_t next_state;
  lpg_tick_t     cnt;
  lpg_tick_t     next_cnt;
  logic          next_led_on;
  wire lpg_tick_t period_ticks = lpg_period_ticks(cfg.period);
  wire lpg_tick_t width_ticks  = lpg_width_ticks(cfg.width);
  wire lpg_tick_t width2       = lpg_tick_t'(width_ticks << 1);
  wire lpg_tick_t width3       = lpg_tick_t'(width2 + width_ticks);
  wire lpg_tick_t cnt_inc      = lpg_tick_t'(cnt + 18'h00001);
  wire            enabled      = (cfg.period != 3'h0);
  wire            wrap         = (cnt_inc >= period_ticks);
  wire            second_pulse = cfg.dbl && (cnt >= width2) && (cnt < width3);
  wire            first_pulse  = (cnt < width_ticks);

  // ==========================================================
  // Sequencer
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_led_on = 1'b0;
    unique case (state)
      LPG_ST_OFF: begin
        next_cnt = lpg_tick_t'(0);
        if (enabled) begin
          next_state = LPG_ST_RUN;
        end
      end
      LPG_ST_RUN: begin
        next_led_on = first_pulse || second_pulse;
        if (lf_tick) begin
          next_cnt = wrap ? lpg_tick_t'(0) : cnt_inc;
        end
      end
    endcase
    if (restart || !enabled) begin
      next_state  = LPG_ST_OFF;
      next_cnt    = lpg_tick_t'(0);
      next_led_on = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state  <= LPG_ST_OFF;
      cnt    <= lpg_tick_t'(0);
      led_on <= 1'b0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      led_on <= next_led_on;
    end
  end

endmodule // lpg_blink_gen

// *** verification/lpg_top_chk.sv ***
// Port checker for the pulse and PWM generator
`timescale 1ns/1ps
`include "lpg_cfg.svh"

module lpg_top_chk #(
  parameter int unsigned LF_DIV_CYCLES = 4
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Indicators, PWM and pin
  input wire logic        first_indicator_out,
  input wire logic        second_indicator_out,
  input wire logic        pwm_out,
  input wire logic        gpio_in,
  input wire logic        gpio_out,
  input wire logic        gpio_oe
);
  // ==========================================================
  // Shadow of written fields
  logic [5:0] per_sh;
  logic [1:0] rate_sh;
  logic [7:0] duty_sh;
  logic [2:0] pin_sh;
  int         quiet;
  int         hi_cnt;
  int         hi_exp;
  wire        wr = psel && penable && pwrite && pready;
  wire        wr_per = wr && (paddr == `LPG_ADDR_PERIOD);
  wire        wr_rate = wr && (paddr == `LPG_ADDR_PULSE_RATE_SELECT);
  wire        wr_duty = wr && (paddr == `LPG_ADDR_PWM_DUTY);
  wire        wr_pin = wr && (paddr == `LPG_ADDR_PIN);
  assign hi_exp = (int'(duty_sh) * `LPG_PWM_STEP_CYCLES) << rate_sh;
  // Quiet counter only gates checks, so its wrap after ages is harmless
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      per_sh <= 6'h00;
      rate_sh <= 2'h0;
      duty_sh <= 8'h00;
      pin_sh <= 3'h0;
      quiet <= 0;
      hi_cnt <= 0;
    end else begin
      quiet <= wr ? 0 : quiet + 1;
      hi_cnt <= pwm_out ? hi_cnt + 1 : 0;
      per_sh <= wr_per ? pwdata[5:0] : per_sh;
      rate_sh <= wr_rate ? pwdata[1:0] : rate_sh;
      duty_sh <= wr_duty ? pwdata[7:0] : duty_sh;
      pin_sh <= wr_pin ? pwdata[2:0] : pin_sh;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Properties
  a_reset_clear: assert property (
    $rose(rst_b) |-> !(first_indicator_out || second_indicator_out || pwm_out || gpio_oe))
    else $error("outputs not clear after reset");
  a_first_off: assert property (
    quiet > 6 && per_sh[2:0] == 3'h0 |-> !first_indicator_out)
    else $error("first indicator lit while off");
  a_second_off: assert property (
    quiet > 6 && per_sh[5:3] == 3'h0 |-> !second_indicator_out)
    else $error("second indicator lit while off");
  a_first_start: assert property (
    wr_per && pwdata[2:0] != 3'h0 && pwdata[2:0] != per_sh[2:0] |-> ##[1:4] first_indicator_out)
    else $error("first indicator did not restart lit");
  a_second_start: assert property (
    wr_per && pwdata[5:3] != 3'h0 && pwdata[5:3] != per_sh[5:3] |-> ##[1:4] second_indicator_out)
    else $error("second indicator did not restart lit");
  a_duty_zero: assert property (
    quiet > 6 && duty_sh == 8'h00 |-> !pwm_out)
    else $error("pwm high at zero duty");
  a_pwm_start: assert property (
    wr_duty && pwdata[7:0] != 8'h00 && pwdata[7:0] != duty_sh |-> ##[1:4] pwm_out)
    else $error("pwm did not restart high");
  a_pwm_high_len: assert property (
    $fell(pwm_out) && quiet > hi_cnt |-> hi_cnt >= hi_exp - 1 && hi_cnt <= hi_exp + 1)
    else $error("pwm high time wrong");
  a_pin_drive: assert property (
    quiet > 6 |-> gpio_oe == pin_sh[1])
    else $error("pin enable wrong");
  a_pin_select: assert property (
    quiet > 6 |-> gpio_out == (pin_sh[2] ? pwm_out : pin_sh[0]))
    else $error("pin value wrong");
endmodule // lpg_top_chk

bind lpg_top lpg_top_chk #(.LF_DIV_CYCLES(LF_DIV_CYCLES)) lpg_top_chk_i (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .first_indicator_out(first_indicator_out), .second_indicator_out(second_indicator_out),
  .pwm_out(pwm_out), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe));

// *** verification/lpg_led_load.sv ***
// Load model that times lit and dark runs of one drive line
`timescale 1ns/1ps

module lpg_led_load (
  // Clock
  input  wire logic core_clk,
  // Drive from the block
  input  wire logic drive,
  // Run lengths in clock cycles and count of rises
  output int        on_len,
  output int        off_len,
  output int        rises
);
  // ==========================================================
  // Run timing
  logic lit = 1'b0;
  int   run = 0;
  always @(posedge core_clk) begin
    if (drive === lit) begin
      run <= run + 1;
    end else begin
      on_len <= lit ? run : on_len;
      off_len <= lit ? off_len : run;
      rises <= rises + ((drive === 1'b1) ? 1 : 0);
      lit <= drive;
      run <= 1;
    end
  end
endmodule // lpg_led_load

// *** verification/lpg_top_bench.sv ***
// Self-checking bench for the pulse and PWM generator
`timescale 1ns/1ps
`include "lpg_cfg.svh"

module lpg_top_bench;
  // ==========================================================
  // Timing from the shortened tick divider
  // Two cycles per tick leaves room for the long period codes
  localparam int DIV = 2;
  localparam int ON_W = `LPG_ON_BASE_TICKS * DIV;
  localparam int PER = `LPG_PERIOD_BASE_TICKS * DIV;
  localparam int STEP = `LPG_PWM_STEP_CYCLES;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ind1;
  logic        ind2;
  logic        pwm;
  logic        gpio_out;
  logic        gpio_oe;
  logic [31:0] rd;
  logic        err;
  int          n_errors;
  int          cmp_count;
  int          cycles;
  int          on1, off1, r1, on2, off2, r2, onp, offp, rp, ong, offg, rg;
  logic [11:0] addrs [4] = '{`LPG_ADDR_PERIOD, `LPG_ADDR_PULSE,
                            `LPG_ADDR_PULSE_RATE_SELECT, `LPG_ADDR_PWM_DUTY};
  logic [31:0] masks [4] = '{32'h3f, 32'h3f, 32'h03, 32'hff};
  // Pull-down holds the pin low once the block lets go of it
  wire         pad = gpio_oe ? gpio_out : 1'b0;

  always #2.5 core_clk = ~core_clk;

  lpg_top #(.LF_DIV_CYCLES(DIV)) lpg_top_i (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_indicator_out(ind1), .second_indicator_out(ind2), .pwm_out(pwm),
    .gpio_in(pad), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  lpg_led_load lpg_led_load_i1 (.core_clk(core_clk), .drive(ind1),
    .on_len(on1), .off_len(off1), .rises(r1));
  lpg_led_load lpg_led_load_i2 (.core_clk(core_clk), .drive(ind2),
    .on_len(on2), .off_len(off2), .rises(r2));
  lpg_led_load lpg_led_load_i3 (.core_clk(core_clk), .drive(pwm),
    .on_len(onp), .off_len(offp), .rises(rp));
  lpg_led_load lpg_led_load_i4 (.core_clk(core_clk), .drive(pad),
    .on_len(ong), .off_len(offg), .rises(rg));

  // ==========================================================
  // Shared tasks
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      $display("unexpected timeout expected end seen hang");
      n_errors++;
      test_done();
    end
  end

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // Load timing is judged within a few cycles of restart latency
  task automatic near(input string what, input int exp, input int got);
    cmp_count++;
    if (got < exp - 3 || got > exp + 3) begin
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
      n_errors++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      apb(addrs[i], 1'b0, 32'h0);
      chk("reset value", 32'h0, rd);
      chk("mapped error", 32'h0, err);
    end
    chk("outputs after reset", 32'h0, {ind1, ind2, pwm, gpio_oe});
    apb(12'h000, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    apb(`LPG_ADDR_STATUS, 1'b1, 32'hf);
    chk("status write error", 32'h1, err);
    $display("test reset done");
  endtask

  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      apb(addrs[i], 1'b1, 32'hffff_ffff);
      apb(addrs[i], 1'b0, 32'h0);
      chk("field mask", masks[i], rd);
      apb(addrs[i], 1'b1, 32'h0);
    end
    $display("test registers done");
  endtask

  task automatic t_blink();
    int b1;
    int b2;
    apb(`LPG_ADDR_PULSE, 1'b1, 32'h20);
    apb(`LPG_ADDR_PERIOD, 1'b1, 32'h12);
    b1 = r1;
    b2 = r2;
    repeat (25000) @(posedge core_clk);
    chk("first pulses", 32'd2, 32'(r1 - b1));
    near("first lit", ON_W, on1);
    near("first dark", 2 * PER - ON_W, off1);
    chk("second pulses", 32'd4, 32'(r2 - b2));
    near("second lit", ON_W, on2);
    near("second dark", ON_W, off2);
    apb(`LPG_ADDR_PERIOD, 1'b1, 32'h0);
    repeat (8) @(posedge core_clk);
    chk("indicators off", 32'h0, {ind1, ind2});
    $display("test indicators done");
  endtask

  task automatic t_double();
    int b1;
    int b2;
    apb(`LPG_ADDR_PULSE, 1'b1, 32'h19);
    apb(`LPG_ADDR_PERIOD, 1'b1, 32'h1b);
    b1 = r1;
    b2 = r2;
    repeat (34000) @(posedge core_clk);
    chk("first double pulses", 32'd3, 32'(r1 - b1));
    near("first wide lit", 2 * ON_W, on1);
    near("first double gap", 2 * ON_W, off1);
    chk("second single pulses", 32'd2, 32'(r2 - b2));
    near("second wide lit", 4 * ON_W, on2);
    near("second long dark", 4 * PER - 4 * ON_W, off2);
    apb(`LPG_ADDR_PERIOD, 1'b1, 32'h0);
    repeat (8) @(posedge core_clk);
    chk("indicators off again", 32'h0, {ind1, ind2});
    $display("test double pulse done");
  endtask

  task automatic t_pwm();
    apb(`LPG_ADDR_PIN, 1'b1, 32'h6);
    apb(`LPG_ADDR_PWM_DUTY, 1'b1, 32'h1);
    for (int r = 0; r < 4; r++) begin
      apb(`LPG_ADDR_PULSE_RATE_SELECT, 1'b1, 32'(r));
      repeat ((STEP << r) + 300) @(posedge core_clk);
      near("pwm high time", STEP << r, onp);
      near("pin high time", STEP << r, ong);
    end
    apb(`LPG_ADDR_PWM_DUTY, 1'b1, 32'h0);
    apb(`LPG_ADDR_PULSE_RATE_SELECT, 1'b1, 32'h0);
    repeat (8) @(posedge core_clk);
    chk("pwm at zero duty", 32'h0, pwm);
    $display("test pwm done");
  endtask

  task automatic t_pin();
    apb(`LPG_ADDR_PIN, 1'b1, 32'h3);
    repeat (8) @(posedge core_clk);
    chk("pin driven high", 32'h3, {gpio_oe, gpio_out});
    apb(`LPG_ADDR_STATUS, 1'b0, 32'h0);
    chk("pin level seen", 32'h8, rd);
    // Level left high so only the pull-down can make the pad read low
    apb(`LPG_ADDR_PIN, 1'b1, 32'h1);
    repeat (8) @(posedge core_clk);
    chk("pin released", 32'h1, {gpio_oe, gpio_out});
    apb(`LPG_ADDR_STATUS, 1'b0, 32'h0);
    chk("pin pulled low", 32'h0, rd);
    $display("test pin done");
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_blink();
    t_double();
    t_pwm();
    t_pin();
    test_done();
  end
endmodule // lpg_top_bench
